// ---- logic/fsr_ctrl.sv ----
// Frequency source selection, programmable N/M and watchdog recovery control
`default_nettype none
module fsr_ctrl
    import fsr_pkg::*;
(
    input wire logic clk, // 10 MHz clock
    input wire logic arst_n, // Asynchronous reset
    input wire logic [4:0] strap_freq_code, // Strap pins
    input wire logic wd_timeout, // Watchdog expiry pulse
    input wire logic ctl_wr, // Control byte write strobe
    input wire logic ctl_rd, // Control byte read strobe
    input wire logic [7:0] ctl_idx, // Control byte index
    input wire logic [7:0] ctl_wdata, // Control byte write data
    output logic [7:0] ctl_rdata, // Read data, valid after ctl_rd
    output logic watchdog_arm, // Watchdog enable level
    output logic recovery_active, // Locked in recovery mode
    output logic sys_reset_n, // System reset pulse
    output logic freq_load, // New frequency load pulse
    output logic [4:0] freq_code, // Code for ratios and gear
    output logic use_nm, // CPU from N/M rather than table
    output logic [1:0] gear_sel, // Gear index
    output logic [31:0] cpu_freq_10hz, // CPU frequency, 10 Hz units
    output logic [11:0] sdram_freq, // SDRAM, 100 kHz units
    output logic [11:0] sixty_six_mhz_clock_freq, // 66 MHz group, 100 kHz units
    output logic [11:0] pci_freq, // PCI, 100 kHz units
    output logic [11:0] apic_freq, // APIC, 100 kHz units
    output logic cpu_out_of_range // CPU outside 50 to 248 MHz
);
    localparam logic [4:0] RST_CNT_LOAD = 5'(SYS_RESET_CYC);
    localparam logic [1:0] STRAP_CNT_END = 2'(STRAP_SETTLE_CYC);

    function automatic logic [31:0] gear_const(input fsr_gear_t g);
        unique case (g)
            FSR_G1: gear_const = GEAR1_10HZ;
            FSR_G2: gear_const = GEAR2_10HZ;
            FSR_G3: gear_const = GEAR3_10HZ;
            FSR_G4: gear_const = GEAR4_10HZ;
        endcase
    endfunction : gear_const

    function automatic logic [31:0] nm_freq(input fsr_gear_t g, input logic [7:0] n, input logic [6:0] m);
        logic [31:0] num;
        logic [31:0] den;
        num = gear_const(g) * (32'(n) + NM_OFFSET);
        den = 32'(m) + NM_OFFSET;
        nm_freq = num / den;
    endfunction : nm_freq

    fsr_sel_if sel ();

    fsr_freq_table u_table (
        .sel(sel.tbl)
    );

    // Strap capture
    logic [4:0] strap_s1_q, strap_s2_q, strap_q, strap_d;
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic strap_done_q, strap_done_d;

    always_comb begin
        strap_cnt_d = strap_cnt_q;
        strap_done_d = strap_done_q;
        strap_d = strap_q;
        if (!strap_done_q) begin
            // Wait for the synchroniser to fill before taking the pins
            if (strap_cnt_q == STRAP_CNT_END) begin
                strap_d = strap_s2_q;
                strap_done_d = 1'b1;
            end else begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1_q <= 5'h00;
            strap_s2_q <= 5'h00;
            strap_q <= 5'h00;
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
        end else begin
            strap_s1_q <= strap_freq_code;
            strap_s2_q <= strap_s1_q;
            strap_q <= strap_d;
            strap_cnt_q <= strap_cnt_d;
            strap_done_q <= strap_done_d;
        end
    end

    // Control bytes and watchdog lock
    logic [4:0] sw_code_q, sw_code_d;
    logic override_q, override_d;
    logic prog_en_q, prog_en_d;
    logic [7:0] prog_n_q, prog_n_d, rec_n_q, rec_n_d;
    logic [6:0] prog_m_q, prog_m_d, rec_m_q, rec_m_d;
    logic rec_sel_q, rec_sel_d;
    logic [7:0] rsvd_a_q, rsvd_a_d, rsvd_b_q, rsvd_b_d;
    logic rsvd_c_q, rsvd_c_d;
    logic arm_q, arm_d, to_status_q, to_status_d, lock_q, lock_d;
    logic [4:0] rst_cnt_q, rst_cnt_d;
    logic load_q, load_d;
    logic [7:0] rdata_q, rdata_d;
    logic wr_ok;

    always_comb begin
        sw_code_d = sw_code_q;
        override_d = override_q;
        prog_en_d = prog_en_q;
        prog_n_d = prog_n_q;
        prog_m_d = prog_m_q;
        rec_n_d = rec_n_q;
        rec_m_d = rec_m_q;
        rec_sel_d = rec_sel_q;
        rsvd_a_d = rsvd_a_q;
        rsvd_b_d = rsvd_b_q;
        rsvd_c_d = rsvd_c_q;
        arm_d = arm_q;
        to_status_d = to_status_q;
        lock_d = lock_q;
        load_d = 1'b0;
        rst_cnt_d = (rst_cnt_q != 5'h00) ? rst_cnt_q - 5'h01 : rst_cnt_q;
        // Frequency bytes are frozen while locked in recovery
        wr_ok = ctl_wr && !lock_q;
        if (ctl_wr && ctl_idx == WD_CTRL_IDX) begin
            arm_d = ctl_wdata[WD_ARM_BIT];
            if (!ctl_wdata[WD_ARM_BIT]) begin
                lock_d = 1'b0;
            end
            if (ctl_wdata[WD_STATUS_BIT]) begin
                to_status_d = 1'b0;
            end
        end
        if (wr_ok && ctl_idx == SEL_CTRL_IDX) begin
            sw_code_d = ctl_wdata[4:0];
            override_d = ctl_wdata[OVERRIDE_BIT];
            load_d = 1'b1;
        end
        if (wr_ok && ctl_idx == PROG_N_IDX) begin
            prog_n_d = ctl_wdata;
            load_d = 1'b1;
        end
        if (wr_ok && ctl_idx == PROG_M_IDX) begin
            prog_m_d = ctl_wdata[6:0];
            prog_en_d = ctl_wdata[PROG_EN_BIT];
            load_d = 1'b1;
        end
        // Recovery values stay writable so software can retune the fallback
        if (ctl_wr && ctl_idx == REC_N_IDX) begin
            rec_n_d = ctl_wdata;
            load_d = lock_q;
        end
        if (ctl_wr && ctl_idx == REC_M_IDX) begin
            rec_m_d = ctl_wdata[6:0];
            rec_sel_d = ctl_wdata[REC_SEL_BIT];
            load_d = lock_q;
        end
        if (ctl_wr && ctl_idx == RSVD_A_IDX) begin
            rsvd_a_d = ctl_wdata;
        end
        if (ctl_wr && ctl_idx == RSVD_B_IDX) begin
            rsvd_b_d = ctl_wdata;
        end
        if (ctl_wr && ctl_idx == RSVD_C_IDX) begin
            rsvd_c_d = ctl_wdata[0];
        end
        // Time-out wins over a clear in the same cycle
        if (wd_timeout) begin
            to_status_d = 1'b1;
            lock_d = 1'b1;
            rst_cnt_d = RST_CNT_LOAD;
            load_d = 1'b1;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (ctl_rd) begin
            unique case (ctl_idx)
                WD_CTRL_IDX: rdata_d = {6'h00, to_status_q, arm_q};
                SEL_CTRL_IDX: rdata_d = {2'h0, override_q, sw_code_q};
                REC_N_IDX: rdata_d = rec_n_q;
                REC_M_IDX: rdata_d = {rec_sel_q, rec_m_q};
                PROG_N_IDX: rdata_d = prog_n_q;
                PROG_M_IDX: rdata_d = {prog_en_q, prog_m_q};
                RSVD_A_IDX: rdata_d = rsvd_a_q;
                RSVD_B_IDX: rdata_d = rsvd_b_q;
                RSVD_C_IDX: rdata_d = {7'h00, rsvd_c_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_code_q <= 5'h00;
            override_q <= 1'b0;
            prog_en_q <= 1'b0;
            prog_n_q <= 8'h00;
            prog_m_q <= 7'h00;
            rec_n_q <= 8'h00;
            rec_m_q <= 7'h00;
            rec_sel_q <= 1'b0;
            rsvd_a_q <= RSVD_A_RESET;
            rsvd_b_q <= RSVD_B_RESET;
            rsvd_c_q <= RSVD_C_RESET;
            arm_q <= 1'b0;
            to_status_q <= 1'b0;
            lock_q <= 1'b0;
            rst_cnt_q <= 5'h00;
            load_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            sw_code_q <= sw_code_d;
            override_q <= override_d;
            prog_en_q <= prog_en_d;
            prog_n_q <= prog_n_d;
            prog_m_q <= prog_m_d;
            rec_n_q <= rec_n_d;
            rec_m_q <= rec_m_d;
            rec_sel_q <= rec_sel_d;
            rsvd_a_q <= rsvd_a_d;
            rsvd_b_q <= rsvd_b_d;
            rsvd_c_q <= rsvd_c_d;
            arm_q <= arm_d;
            to_status_q <= to_status_d;
            lock_q <= lock_d;
            rst_cnt_q <= rst_cnt_d;
            load_q <= load_d;
            rdata_q <= rdata_d;
        end
    end

    // Frequency source selection
    logic [4:0] ratio_code;
    logic nm_sel;
    logic [7:0] n_sel;
    logic [6:0] m_sel;
    logic [31:0] cpu_d, cpu_q;
    logic [4:0] code_q;
    logic nm_q;
    logic [1:0] gear_q;
    logic [11:0] sdram_q, mhz66_q, pci_q, apic_q;
    logic range_d, range_q;

    always_comb begin
        ratio_code = override_q ? sw_code_q : strap_q;
        nm_sel = 1'b0;
        n_sel = prog_n_q;
        m_sel = prog_m_q;
        if (lock_q) begin
            if (rec_sel_q) begin
                nm_sel = 1'b1;
                n_sel = rec_n_q;
                m_sel = rec_m_q;
            end else begin
                ratio_code = strap_q;
            end
        end else begin
            nm_sel = prog_en_q;
        end
        sel.code = ratio_code;
        cpu_d = nm_sel ? nm_freq(sel.gear, n_sel, m_sel) : 32'(sel.cpu) * TABLE_TO_10HZ;
        range_d = (cpu_d < CPU_MIN_10HZ) || (cpu_d > CPU_MAX_10HZ);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_q <= 5'h00;
            nm_q <= 1'b0;
            gear_q <= 2'h0;
            cpu_q <= 32'h0000_0000;
            sdram_q <= 12'h000;
            mhz66_q <= 12'h000;
            pci_q <= 12'h000;
            apic_q <= 12'h000;
            range_q <= 1'b0;
        end else begin
            code_q <= ratio_code;
            nm_q <= nm_sel;
            gear_q <= sel.gear;
            cpu_q <= cpu_d;
            sdram_q <= sel.sdram;
            mhz66_q <= sel.mhz66;
            pci_q <= sel.pci;
            apic_q <= sel.apic;
            range_q <= range_d;
        end
    end

    assign ctl_rdata = rdata_q;
    assign watchdog_arm = arm_q;
    assign recovery_active = lock_q;
    assign sys_reset_n = (rst_cnt_q == 5'h00);
    assign freq_load = load_q;
    assign freq_code = code_q;
    assign use_nm = nm_q;
    assign gear_sel = gear_q;
    assign cpu_freq_10hz = cpu_q;
    assign sdram_freq = sdram_q;
    assign sixty_six_mhz_clock_freq = mhz66_q;
    assign pci_freq = pci_q;
    assign apic_freq = apic_q;
    assign cpu_out_of_range = range_q;
endmodule : fsr_ctrl
`default_nettype wire

// ---- logic/fsr_freq_table.sv ----
// Selection code to output frequency set, 100 kHz units
`default_nettype none
module fsr_freq_table
    import fsr_pkg::*;
(
    fsr_sel_if.tbl sel // Code in, frequency set out
);
    function automatic logic [61:0] row(input logic [4:0] c);
        unique case (c)
            5'h00: row = {FSR_G1, 12'd666, 12'd1000, 12'd666, 12'd333, 12'd166};
            5'h01: row = {FSR_G2, 12'd1200, 12'd1200, 12'd800, 12'd400, 12'd200};
            5'h02: row = {FSR_G1, 12'd668, 12'd1002, 12'd668, 12'd334, 12'd167};
            5'h03: row = {FSR_G1, 12'd683, 12'd1025, 12'd683, 12'd342, 12'd171};
            5'h04: row = {FSR_G1, 12'd700, 12'd1050, 12'd700, 12'd350, 12'd175};
            5'h05: row = {FSR_G1, 12'd750, 12'd1125, 12'd750, 12'd375, 12'd188};
            5'h06: row = {FSR_G1, 12'd800, 12'd1200, 12'd800, 12'd400, 12'd200};
            5'h07: row = {FSR_G1, 12'd830, 12'd1245, 12'd830, 12'd415, 12'd208};
            5'h08: row = {FSR_G2, 12'd1000, 12'd1000, 12'd666, 12'd333, 12'd166};
            5'h09: row = {FSR_G2, 12'd1240, 12'd1240, 12'd826, 12'd413, 12'd206};
            5'h0a: row = {FSR_G2, 12'd1002, 12'd1002, 12'd668, 12'd334, 12'd167};
            5'h0b: row = {FSR_G2, 12'd1030, 12'd1030, 12'd689, 12'd343, 12'd172};
            5'h0c: row = {FSR_G2, 12'd1050, 12'd1050, 12'd700, 12'd350, 12'd175};
            5'h0d: row = {FSR_G2, 12'd1100, 12'd1100, 12'd733, 12'd367, 12'd183};
            5'h0e: row = {FSR_G2, 12'd1150, 12'd1150, 12'd766, 12'd383, 12'd191};
            5'h0f: row = {FSR_G4, 12'd2000, 12'd2000, 12'd666, 12'd333, 12'd166};
            5'h10: row = {FSR_G3, 12'd1333, 12'd1333, 12'd666, 12'd333, 12'd166};
            5'h11: row = {FSR_G3, 12'd1666, 12'd1666, 12'd833, 12'd416, 12'd208};
            5'h12: row = {FSR_G3, 12'd1336, 12'd1336, 12'd668, 12'd334, 12'd167};
            5'h13: row = {FSR_G3, 12'd1370, 12'd1370, 12'd685, 12'd343, 12'd171};
            5'h14: row = {FSR_G3, 12'd1400, 12'd1400, 12'd700, 12'd350, 12'd175};
            5'h15: row = {FSR_G3, 12'd1450, 12'd1450, 12'd725, 12'd362, 12'd181};
            5'h16: row = {FSR_G3, 12'd1500, 12'd1500, 12'd750, 12'd375, 12'd187};
            5'h17: row = {FSR_G3, 12'd1600, 12'd1600, 12'd800, 12'd400, 12'd200};
            5'h18: row = {FSR_G3, 12'd1333, 12'd1000, 12'd666, 12'd333, 12'd166};
            5'h19: row = {FSR_G3, 12'd1666, 12'd1250, 12'd833, 12'd417, 12'd208};
            5'h1a: row = {FSR_G3, 12'd1336, 12'd1002, 12'd668, 12'd334, 12'd167};
            5'h1b: row = {FSR_G3, 12'd1370, 12'd1028, 12'd685, 12'd343, 12'd171};
            5'h1c: row = {FSR_G1, 12'd666, 12'd1000, 12'd666, 12'd333, 12'd166};
            5'h1d: row = {FSR_G2, 12'd1000, 12'd1000, 12'd666, 12'd333, 12'd166};
            5'h1e: row = {FSR_G3, 12'd1333, 12'd1333, 12'd666, 12'd333, 12'd166};
            5'h1f: row = {FSR_G3, 12'd1333, 12'd1000, 12'd666, 12'd333, 12'd166};
        endcase
    endfunction : row

    logic [1:0] gear_bits;

    // Enum field cannot take raw bits, so unpack then cast
    always_comb begin
        {gear_bits, sel.cpu, sel.sdram, sel.mhz66, sel.pci, sel.apic} = row(sel.code);
        sel.gear = fsr_gear_t'(gear_bits);
    end
endmodule : fsr_freq_table
`default_nettype wire

// ---- logic/fsr_pkg.sv ----
// Constants and types for the frequency select and recovery control block
`default_nettype none
package fsr_pkg;
    // Control byte indices
    localparam logic [7:0] WD_CTRL_IDX = 8'h09;
    localparam logic [7:0] SEL_CTRL_IDX = 8'h0a;
    localparam logic [7:0] REC_N_IDX = 8'h0b;
    localparam logic [7:0] REC_M_IDX = 8'h0c;
    localparam logic [7:0] PROG_N_IDX = 8'h0d;
    localparam logic [7:0] PROG_M_IDX = 8'h0e;
    localparam logic [7:0] RSVD_A_IDX = 8'h0f;
    localparam logic [7:0] RSVD_B_IDX = 8'h10;
    localparam logic [7:0] RSVD_C_IDX = 8'h11;

    // Field positions
    localparam int WD_ARM_BIT = 0;
    localparam int WD_STATUS_BIT = 1;
    localparam int OVERRIDE_BIT = 5;
    localparam int PROG_EN_BIT = 7;
    localparam int REC_SEL_BIT = 7;

    // Reset values
    localparam logic [7:0] RSVD_A_RESET = 8'h03;
    localparam logic [7:0] RSVD_B_RESET = 8'h00;
    localparam logic RSVD_C_RESET = 1'b0;

    // Gear constants in units of 10 Hz
    localparam logic [31:0] GEAR1_10HZ = 32'h0030_d5ee;
    localparam logic [31:0] GEAR2_10HZ = 32'h0049_40e5;
    localparam logic [31:0] GEAR3_10HZ = 32'h0061_abdc;
    localparam logic [31:0] GEAR4_10HZ = 32'h0092_81ca;
    localparam logic [31:0] NM_OFFSET = 32'h0000_0003;
    localparam logic [31:0] TABLE_TO_10HZ = 32'h0000_2710;

    // CPU frequency limits, 10 Hz units (50 MHz and 248 MHz)
    localparam logic [31:0] CPU_MIN_10HZ = 32'h004c_4b40;
    localparam logic [31:0] CPU_MAX_10HZ = 32'h017a_6b00;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYS_RESET_NS = 2000;
    localparam int SYS_RESET_CYC = (SYS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CYC = 3;

    typedef enum logic [1:0] {FSR_G1, FSR_G2, FSR_G3, FSR_G4} fsr_gear_t;
endpackage : fsr_pkg
`default_nettype wire

// ---- logic/fsr_sel_if.sv ----
// Code to frequency set lookup between control and table modules
`default_nettype none
interface fsr_sel_if;
    import fsr_pkg::*;
    logic [4:0] code;
    fsr_gear_t gear;
    logic [11:0] cpu;
    logic [11:0] sdram;
    logic [11:0] mhz66;
    logic [11:0] pci;
    logic [11:0] apic;
    modport req (output code, input gear, cpu, sdram, mhz66, pci, apic);
    modport tbl (input code, output gear, cpu, sdram, mhz66, pci, apic);
endinterface : fsr_sel_if
`default_nettype wire

// ---- tb/fsr_ctrl_assertions.sv ----
// Port-level temporal checks for the frequency select and recovery control
`default_nettype none
module fsr_ctrl_assertions
    import fsr_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic wd_timeout, // Expiry pulse
    input wire logic ctl_wr, // Write strobe
    input wire logic ctl_rd, // Read strobe
    input wire logic [7:0] ctl_idx, // Byte index
    input wire logic [7:0] ctl_wdata, // Write data
    input wire logic [7:0] ctl_rdata, // Read data
    input wire logic watchdog_arm, // Arm level
    input wire logic recovery_active, // Lock level
    input wire logic sys_reset_n, // System reset
    input wire logic freq_load, // Load pulse
    input wire logic [4:0] freq_code, // Ratio code
    input wire logic [1:0] gear_sel, // Gear index
    input wire logic [31:0] cpu_freq_10hz, // CPU frequency
    input wire logic cpu_out_of_range // Range flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic op_wr;
    logic unlock_wr;
    assign op_wr = ctl_wr && (ctl_idx == SEL_CTRL_IDX || ctl_idx == PROG_N_IDX || ctl_idx == PROG_M_IDX);
    assign unlock_wr = ctl_wr && ctl_idx == WD_CTRL_IDX && !ctl_wdata[WD_ARM_BIT];
    chk_write_load: assert property (op_wr && !recovery_active |=> freq_load)
        else $error("Frequency write gave no load pulse");
    chk_timeout_lock: assert property (wd_timeout |=> recovery_active && freq_load && !sys_reset_n)
        else $error("Expiry did not lock, load and reset");
    chk_reset_width: assert property (wd_timeout |=> !sys_reset_n ##19 !sys_reset_n ##1 sys_reset_n)
        else $error("System reset pulse width wrong");
    chk_locked_quiet: assert property (op_wr && recovery_active && !wd_timeout |=> !freq_load)
        else $error("Locked block accepted a frequency write");
    chk_lock_holds: assert property (recovery_active && !unlock_wr |=> recovery_active)
        else $error("Recovery lock dropped without unlock");
    chk_unlock_write: assert property (unlock_wr && !wd_timeout |=> !recovery_active && !watchdog_arm)
        else $error("Clearing the arm bit did not unlock");
    chk_arm_level: assert property (ctl_wr && ctl_idx == WD_CTRL_IDX |=> watchdog_arm == $past(ctl_wdata[0]))
        else $error("Arm level does not follow write");
    chk_rsvd_zero: assert property (ctl_rd && ctl_idx == RSVD_C_IDX |=> ctl_rdata[7:1] == 7'h00)
        else $error("Reserved byte upper bits not zero");
    chk_range_flag: assert property ($stable(cpu_freq_10hz) && cpu_freq_10hz != 32'h0 |->
        cpu_out_of_range == (cpu_freq_10hz < CPU_MIN_10HZ || cpu_freq_10hz > CPU_MAX_10HZ))
        else $error("Range flag disagrees with CPU frequency");
    chk_top_gear: assert property ($stable(freq_code) && $stable(gear_sel) |->
        (freq_code == 5'h0f) == (gear_sel == 2'h3))
        else $error("Top gear not tied to its code");
endmodule : fsr_ctrl_assertions
bind fsr_ctrl fsr_ctrl_assertions i_chk (.clk, .arst_n, .wd_timeout, .ctl_wr, .ctl_rd, .ctl_idx, .ctl_wdata,
    .ctl_rdata, .watchdog_arm, .recovery_active, .sys_reset_n, .freq_load, .freq_code, .gear_sel,
    .cpu_freq_10hz, .cpu_out_of_range);
`default_nettype wire

// ---- tb/fsr_ctrl_tb.sv ----
// Self-checking bench for the frequency select and recovery control
`default_nettype none
module fsr_ctrl_tb import fsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // Code tables, code 0 first: cpu, sdram, 66 MHz group, pci, apic
    localparam logic [383:0] TBL [5] = '{
        {192'h29a4b029c2ab2bc2ee32033e3e84d83ea40641a44c47e7d0, 192'h53568253855a5785aa5dc64053568253855a29a3e8535535},
        {192'h3e84b03ea40141a4654b04dd3e84d83ea40641a44c47e7d0, 192'h53568253855a5785aa5dc6403e84e23ea4043e83e85353e8},
        {192'h29a32029c2ab2bc2ee32033e29a33a29c2b12bc2dd2fe29a, 192'h29a34129c2ad2bc2d52ee32029a34129c2ad29a29a29a29a},
        {192'h14d19014e15615e17719019f14d19d14e15715e16f17f14d, 192'h14d1a014e15715e16a17719014d1a114e15714d14d14d14d},
        {192'h0a60c80a70ab0af0bc0c80d00a60ce0a70ac0af0b70bf0a6, 192'h0a60d00a70ab0af0b50bb0c80a60d00a70ab0a60a60a60a6}};
    localparam logic [63:0] GEARS = 64'h1000_5557_aaaa_aa1a;
    localparam logic [31:0] GC [4] = '{GEAR1_10HZ, GEAR2_10HZ, GEAR3_10HZ, GEAR4_10HZ};
    logic clk, arst_n, ctl_wr, ctl_rd, wd_timeout, watchdog_arm, recovery_active, sys_reset_n, freq_load;
    logic use_nm, cpu_out_of_range, ovr, pen, rsel, rec;
    logic [4:0] strap_freq_code, freq_code, sw, strap;
    logic [7:0] ctl_idx, ctl_wdata, ctl_rdata, pn, rn;
    logic [6:0] pm, rm;
    logic [1:0] gear_sel;
    logic [31:0] cpu_freq_10hz;
    logic [11:0] sdram_freq, sixty_six_mhz_clock_freq, pci_freq, apic_freq;
    logic [16:0] rnd = 17'h124e1;
    int checks = 0;
    int fail_count = 0;
    int cycles = 0;
    fsr_host_model i_host (.clk, .ctl_wr, .ctl_rd, .ctl_idx, .ctl_wdata, .wd_timeout);
    fsr_ctrl i_dut (.clk, .arst_n, .strap_freq_code, .wd_timeout, .ctl_wr, .ctl_rd, .ctl_idx, .ctl_wdata,
        .ctl_rdata, .watchdog_arm, .recovery_active, .sys_reset_n, .freq_load, .freq_code, .use_nm, .gear_sel,
        .cpu_freq_10hz, .sdram_freq, .sixty_six_mhz_clock_freq, .pci_freq, .apic_freq, .cpu_out_of_range);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    function automatic logic [11:0] ent(input int k, input logic [4:0] c);
        ent = TBL[k][(31 - int'(c)) * 12 +: 12];
    endfunction : ent
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    // Mirror of accepted control writes; locked frequency bytes are dropped
    task automatic note(input logic [7:0] i, input logic [7:0] d);
        if (!rec || !(i == SEL_CTRL_IDX || i == PROG_N_IDX || i == PROG_M_IDX)) begin
            case (i)
                WD_CTRL_IDX: rec = rec && d[0];
                SEL_CTRL_IDX: {ovr, sw} = d[5:0];
                REC_N_IDX: rn = d;
                REC_M_IDX: {rsel, rm} = d;
                PROG_N_IDX: pn = d;
                PROG_M_IDX: {pen, pm} = d;
                default: ;
            endcase
        end
    endtask : note
    task automatic put(input logic [7:0] i, input logic [7:0] d);
        i_host.wr(i, d);
        note(i, d);
    endtask : put
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] exp, input logic [7:0] m);
        i_host.rd(i);
        @(posedge clk);
        #1;
        check(ctl_rdata & m, exp);
    endtask : rd_chk
    task automatic expect_all();
        logic [4:0] c;
        logic nm;
        logic [1:0] g;
        longint f;
        repeat (3) @(posedge clk);
        #1;
        c = (rec && !rsel) ? strap : (ovr ? sw : strap);
        nm = rec ? rsel : pen;
        g = GEARS[(31 - int'(c)) * 2 +: 2];
        f = longint'(ent(0, c)) * 10000;
        if (nm) begin
            f = longint'(GC[g]) * (int'(rec ? rn : pn) + 3) / (int'(rec ? rm : pm) + 3);
        end
        check(freq_code, c);
        check(use_nm, nm);
        check(gear_sel, g);
        check(cpu_freq_10hz, f[31:0]);
        check(cpu_out_of_range, f < CPU_MIN_10HZ || f > CPU_MAX_10HZ);
        if (!nm) begin
            check(sdram_freq, ent(1, c));
            check(sixty_six_mhz_clock_freq, ent(2, c));
            check(pci_freq, ent(3, c));
            check(apic_freq, ent(4, c));
        end
    endtask : expect_all
    initial begin
        arst_n = 1'b0;
        strap_freq_code = rnd[4:0];
        strap = rnd[4:0];
        {sw, ovr, pen, pn, pm, rsel, rn, rm, rec} = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        strap_freq_code <= ~strap;
        expect_all();
        rd_chk(RSVD_A_IDX, 8'h03, 8'hff);
        rd_chk(RSVD_B_IDX, 8'h00, 8'hff);
        rd_chk(RSVD_C_IDX, 8'h00, 8'hff);
        rd_chk(8'h20, 8'h00, 8'hff);
        put(RSVD_C_IDX, 8'hff);
        rd_chk(RSVD_C_IDX, 8'h01, 8'hff);
        for (int k = 0; k < 32; k++) begin
            put(SEL_CTRL_IDX, 8'h20 | k[7:0]);
            expect_all();
        end
        put(SEL_CTRL_IDX, 8'h1a);
        expect_all();
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            put(SEL_CTRL_IDX, {2'b00, k[0], rnd[4:0]});
            rnd = lfsr(lfsr(rnd));
            i_host.wr_pair(PROG_N_IDX, rnd[7:0], PROG_M_IDX, {1'b1, rnd[14:8]});
            note(PROG_N_IDX, rnd[7:0]);
            note(PROG_M_IDX, {1'b1, rnd[14:8]});
            expect_all();
        end
        put(PROG_N_IDX, 8'h4d);
        #1;
        check(freq_load, 1'b1);
        expect_all();
        put(REC_N_IDX, 8'h6a);
        put(REC_M_IDX, 8'ha7);
        put(WD_CTRL_IDX, 8'h01);
        i_host.expire();
        rec = 1'b1;
        #1;
        check(sys_reset_n, 1'b0);
        check(recovery_active, 1'b1);
        expect_all();
        put(PROG_M_IDX, 8'h85);
        put(SEL_CTRL_IDX, 8'h3f);
        expect_all();
        put(REC_N_IDX, 8'h10);
        #1;
        check(freq_load, 1'b1);
        expect_all();
        rd_chk(WD_CTRL_IDX, 8'h03, 8'h03);
        // Reset pulse ends exactly 20 edges after the expiry edge
        @(posedge clk);
        #1;
        check(sys_reset_n, 1'b0);
        @(posedge clk);
        #1;
        check(sys_reset_n, 1'b1);
        put(WD_CTRL_IDX, 8'h02);
        expect_all();
        rd_chk(WD_CTRL_IDX, 8'h00, 8'h03);
        put(REC_M_IDX, 8'h30);
        put(WD_CTRL_IDX, 8'h01);
        i_host.expire();
        rec = 1'b1;
        expect_all();
        conclude();
    end
endmodule : fsr_ctrl_tb
`default_nettype wire

// ---- tb/fsr_host_model.sv ----
// Control byte host and watchdog expiry source facing the block
`default_nettype none
module fsr_host_model (
    input wire logic clk, // Clock
    output logic ctl_wr, // Write strobe
    output logic ctl_rd, // Read strobe
    output logic [7:0] ctl_idx, // Byte index
    output logic [7:0] ctl_wdata, // Write data
    output logic wd_timeout // Watchdog expiry pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {ctl_wr, ctl_rd, ctl_idx, ctl_wdata, wd_timeout} = '0;
    end
    task automatic drive(input logic w, input logic r, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        {ctl_wr, ctl_rd, ctl_idx, ctl_wdata} <= {w, r, i, d};
    endtask : drive
    // Released lines flip so stale index or data never looks valid
    task automatic idle();
        drive(1'b0, 1'b0, ~ctl_idx, ~ctl_wdata);
    endtask : idle
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        drive(1'b1, 1'b0, i, d);
        idle();
    endtask : wr
    // Both halves on back-to-back cycles, so new N runs with old M for one cycle
    task automatic wr_pair(input logic [7:0] i0, input logic [7:0] d0, input logic [7:0] i1, input logic [7:0] d1);
        drive(1'b1, 1'b0, i0, d0);
        drive(1'b1, 1'b0, i1, d1);
        idle();
    endtask : wr_pair
    task automatic rd(input logic [7:0] i);
        drive(1'b0, 1'b1, i, ~ctl_wdata);
        idle();
    endtask : rd
    task automatic expire();
        @(posedge clk);
        wd_timeout <= 1'b1;
        @(posedge clk);
        wd_timeout <= 1'b0;
    endtask : expire
endmodule : fsr_host_model
`default_nettype wire
